// ---- rtl/oevm_cmp.sv ----
// oevm_cmp: one threshold comparison with its action gating
`timescale 1ns/10ps
module oevm_cmp (
    input wire logic [oevm_pkg::MEAS_W-1:0] meas_in,
    input wire logic [oevm_pkg::MEAS_W-1:0] thr_in,
    input wire logic over_in,
    input wire logic out_on_in,
    input wire logic [1:0] action_in,
    output logic hit_out,
    output logic alarm_out
);

    // ------------------------------------------------------------
    // comparison
    // ------------------------------------------------------------
    logic cond;
    logic enabled;

    // over events trip above, under events below the threshold
    assign cond = over_in ? (meas_in > thr_in) : (meas_in < thr_in);
    assign enabled = (action_in != 2'(oevm_pkg::OEVM_ACT_NONE));
    // no event while the output is off, even as it decays
    assign hit_out = cond && enabled && out_on_in;
    // signal and warning only flag; alarm also trips output
    assign alarm_out = hit_out &&
        (action_in == 2'(oevm_pkg::OEVM_ACT_ALARM));

endmodule : oevm_cmp

// ---- rtl/oevm_pkg.sv ----
// oevm_pkg: shared constants and types of the output event monitor
package oevm_pkg;

    // ------------------------------------------------------------
    // widths and event indices
    // ------------------------------------------------------------
    localparam int MEAS_W = 16;
    localparam int NUM_EV = 5;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    localparam int EV_UV = 0; // undervoltage_event
    localparam int EV_OV = 1; // overvoltage_event
    localparam int EV_UC = 2; // undercurrent_event
    localparam int EV_OC = 3; // overcurrent_event
    localparam int EV_OP = 4; // overpower_event

    // ------------------------------------------------------------
    // event actions
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OEVM_ACT_NONE = 2'h0,
        OEVM_ACT_SIGNAL = 2'h1,
        OEVM_ACT_WARNING = 2'h2,
        OEVM_ACT_ALARM = 2'h3
    } oevm_action_t;

    // ------------------------------------------------------------
    // register offsets (word index on the plain port)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ACTION = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_MASK = 4'h3;
    localparam logic [3:0] REG_UV_THR = 4'h4;
    localparam logic [3:0] REG_OV_THR = 4'h5;
    localparam logic [3:0] REG_UC_THR = 4'h6;
    localparam logic [3:0] REG_OC_THR = 4'h7;
    localparam logic [3:0] REG_OP_THR = 4'h8;
    localparam logic [3:0] REG_NOMINAL_V = 4'h9;
    localparam logic [3:0] REG_NOMINAL_I = 4'hA;
    localparam logic [3:0] REG_NOMINAL_P = 4'hB;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_ON_BIT = 0;     // write 1: switch output on
    localparam int CTRL_OFF_BIT = 1;    // write 1: switch output off
    localparam int STAT_ALARM_OFF_BIT = 5; // output tripped by alarm
    localparam int STAT_OUT_ON_BIT = 6;    // output state, read only
    localparam logic [9:0] ACTION_RST = 10'h000;
    localparam logic [5:0] MASK_RST = 6'h00;
    localparam logic [MEAS_W-1:0] THR_RST = 16'h0000;
    localparam logic [MEAS_W-1:0] NOM_V_DEF = 16'hFFFF;
    localparam logic [MEAS_W-1:0] NOM_I_DEF = 16'hFFFF;
    localparam logic [MEAS_W-1:0] NOM_P_DEF = 16'hFFFF;

endpackage : oevm_pkg

// ---- rtl/oevm_sync.sv ----
// oevm_sync: two flip-flop synchroniser for one vector of pins
`timescale 1ns/10ps
module oevm_sync #(
    parameter int W = 16
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;
    logic [W-1:0] word_ff;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    // bits of one word may settle on different edges, so a word is
    // taken only once two synchronised samples agree; this costs two
    // cycles, and a word that changes on every edge keeps the old one
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prev_ff <= '0;
            word_ff <= '0;
        end else begin
            prev_ff <= sync_ff;
            if (sync_ff == prev_ff) begin
                word_ff <= sync_ff;
            end
        end
    end

    assign q_out = word_ff;

endmodule : oevm_sync

// ---- rtl/oevm_top.sv ----
// oevm_top: output event monitor with register port and interrupt
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module oevm_top (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [oevm_pkg::MEAS_W-1:0] meas_volt_in,
    input wire logic [oevm_pkg::MEAS_W-1:0] meas_curr_in,
    input wire logic [oevm_pkg::MEAS_W-1:0] meas_pwr_in,
    input wire logic [oevm_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [oevm_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [oevm_pkg::DATA_W-1:0] reg_rdata_out,
    output logic output_on_out,
    output logic irq_out
);

    localparam int MW = oevm_pkg::MEAS_W;
    localparam int NE = oevm_pkg::NUM_EV;

    // ------------------------------------------------------------
    // measurement synchronisers
    // ------------------------------------------------------------
    logic [MW-1:0] volt_s;
    logic [MW-1:0] curr_s;
    logic [MW-1:0] pwr_s;

    // measurements come from converters on another clock
    oevm_sync #(.W(MW)) u_sync_v (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .d_in(meas_volt_in),
        .q_out(volt_s)
    );
    oevm_sync #(.W(MW)) u_sync_i (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .d_in(meas_curr_in),
        .q_out(curr_s)
    );
    oevm_sync #(.W(MW)) u_sync_p (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .d_in(meas_pwr_in),
        .q_out(pwr_s)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [2*NE-1:0] action_ff;
    logic [NE:0] status_ff;
    logic [NE:0] mask_ff;
    logic [MW-1:0] thr_ff [NE];
    logic [MW-1:0] nom_v_ff;
    logic [MW-1:0] nom_i_ff;
    logic [MW-1:0] nom_p_ff;
    logic out_on_ff;
    logic irq_ff;
    logic [oevm_pkg::DATA_W-1:0] rdata_ff;

    // limit a written threshold to the range zero..nominal
    function automatic logic [MW-1:0] clamp_thr(
        input logic [MW-1:0] val,
        input logic [MW-1:0] nom
    );
        clamp_thr = (val > nom) ? nom : val;
    endfunction : clamp_thr

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire wr_ctrl = reg_wr_in && (reg_addr_in == oevm_pkg::REG_CTRL);
    wire wr_act = reg_wr_in && (reg_addr_in == oevm_pkg::REG_ACTION);
    wire wr_stat = reg_wr_in && (reg_addr_in == oevm_pkg::REG_STATUS);
    wire wr_mask = reg_wr_in && (reg_addr_in == oevm_pkg::REG_MASK);
    wire wr_nv = reg_wr_in && (reg_addr_in == oevm_pkg::REG_NOMINAL_V);
    wire wr_ni = reg_wr_in && (reg_addr_in == oevm_pkg::REG_NOMINAL_I);
    wire wr_np = reg_wr_in && (reg_addr_in == oevm_pkg::REG_NOMINAL_P);
    wire [NE-1:0] wr_thr;
    assign wr_thr[oevm_pkg::EV_UV] = reg_wr_in &&
        (reg_addr_in == oevm_pkg::REG_UV_THR);
    assign wr_thr[oevm_pkg::EV_OV] = reg_wr_in &&
        (reg_addr_in == oevm_pkg::REG_OV_THR);
    assign wr_thr[oevm_pkg::EV_UC] = reg_wr_in &&
        (reg_addr_in == oevm_pkg::REG_UC_THR);
    assign wr_thr[oevm_pkg::EV_OC] = reg_wr_in &&
        (reg_addr_in == oevm_pkg::REG_OC_THR);
    assign wr_thr[oevm_pkg::EV_OP] = reg_wr_in &&
        (reg_addr_in == oevm_pkg::REG_OP_THR);

    // nominal that bounds each threshold
    wire [MW-1:0] thr_nom [NE];
    assign thr_nom[oevm_pkg::EV_UV] = nom_v_ff;
    assign thr_nom[oevm_pkg::EV_OV] = nom_v_ff;
    assign thr_nom[oevm_pkg::EV_UC] = nom_i_ff;
    assign thr_nom[oevm_pkg::EV_OC] = nom_i_ff;
    assign thr_nom[oevm_pkg::EV_OP] = nom_p_ff;

    wire [MW-1:0] wr_val = reg_wdata_in[MW-1:0];

    // ------------------------------------------------------------
    // event comparators
    // ------------------------------------------------------------
    wire [MW-1:0] ev_meas [NE];
    wire [NE-1:0] ev_over;
    assign ev_meas[oevm_pkg::EV_UV] = volt_s;
    assign ev_meas[oevm_pkg::EV_OV] = volt_s;
    assign ev_meas[oevm_pkg::EV_UC] = curr_s;
    assign ev_meas[oevm_pkg::EV_OC] = curr_s;
    assign ev_meas[oevm_pkg::EV_OP] = pwr_s;
    assign ev_over[oevm_pkg::EV_UV] = 1'b0;
    assign ev_over[oevm_pkg::EV_OV] = 1'b1;
    assign ev_over[oevm_pkg::EV_UC] = 1'b0;
    assign ev_over[oevm_pkg::EV_OC] = 1'b1;
    assign ev_over[oevm_pkg::EV_OP] = 1'b1;

    wire [NE-1:0] ev_hit;
    wire [NE-1:0] ev_alarm;

    // each event reads only its own two action bits
    genvar g;
    generate
        for (g = 0; g < NE; g++) begin : g_ev
            oevm_cmp u_cmp (
                .meas_in(ev_meas[g]),
                .thr_in(thr_ff[g]),
                .over_in(ev_over[g]),
                .out_on_in(out_on_ff),
                .action_in(action_ff[2*g +: 2]),
                .hit_out(ev_hit[g]),
                .alarm_out(ev_alarm[g])
            );
        end
    endgenerate

    wire any_alarm = |ev_alarm;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    wire [NE:0] stat_evt = {any_alarm, ev_hit};
    wire [NE:0] stat_clr = wr_stat ? reg_wdata_in[NE:0] : '0;
    // set beats a clear in the same cycle; bits otherwise hold
    wire [NE:0] nxt_status = (status_ff & ~stat_clr) | stat_evt;

    // alarm wins over a host switch-on in the same cycle
    wire nxt_out_on = any_alarm ? 1'b0 :
        (wr_ctrl && reg_wdata_in[oevm_pkg::CTRL_OFF_BIT]) ? 1'b0 :
        (wr_ctrl && reg_wdata_in[oevm_pkg::CTRL_ON_BIT]) ? 1'b1 :
        out_on_ff;

    wire nxt_irq = |(nxt_status & mask_ff);

    // read mux; unmapped addresses read zero
    logic [oevm_pkg::DATA_W-1:0] nxt_rdata;
    always_comb begin
        nxt_rdata = '0;
        unique case (reg_addr_in)
            oevm_pkg::REG_CTRL:
                nxt_rdata[oevm_pkg::CTRL_ON_BIT] = out_on_ff;
            oevm_pkg::REG_ACTION: nxt_rdata[2*NE-1:0] = action_ff;
            oevm_pkg::REG_STATUS: begin
                nxt_rdata[NE:0] = status_ff;
                nxt_rdata[oevm_pkg::STAT_OUT_ON_BIT] = out_on_ff;
            end
            oevm_pkg::REG_MASK: nxt_rdata[NE:0] = mask_ff;
            oevm_pkg::REG_UV_THR: nxt_rdata[MW-1:0] = thr_ff[oevm_pkg::EV_UV];
            oevm_pkg::REG_OV_THR: nxt_rdata[MW-1:0] = thr_ff[oevm_pkg::EV_OV];
            oevm_pkg::REG_UC_THR: nxt_rdata[MW-1:0] = thr_ff[oevm_pkg::EV_UC];
            oevm_pkg::REG_OC_THR: nxt_rdata[MW-1:0] = thr_ff[oevm_pkg::EV_OC];
            oevm_pkg::REG_OP_THR: nxt_rdata[MW-1:0] = thr_ff[oevm_pkg::EV_OP];
            oevm_pkg::REG_NOMINAL_V: nxt_rdata[MW-1:0] = nom_v_ff;
            oevm_pkg::REG_NOMINAL_I: nxt_rdata[MW-1:0] = nom_i_ff;
            oevm_pkg::REG_NOMINAL_P: nxt_rdata[MW-1:0] = nom_p_ff;
            default: nxt_rdata = '0;
        endcase
    end

    // ------------------------------------------------------------
    // control and status flops
    // ------------------------------------------------------------
    // actions reset to none so nothing fires before setup
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            action_ff <= oevm_pkg::ACTION_RST;
        end else if (wr_act) begin
            action_ff <= reg_wdata_in[2*NE-1:0];
        end
    end

    // the mask gates only the interrupt, never the status bits
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mask_ff <= oevm_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_ff <= reg_wdata_in[NE:0];
        end
    end

    // status holds each event until the host writes a one to it,
    // so a short event between two polls is not lost
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // output state; an alarm forces it low whatever the host asks
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_on_ff <= 1'b0;
        end else begin
            out_on_ff <= nxt_out_on;
        end
    end

    // built from the next status so it rises with the status bit
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= reg_rd_in ? nxt_rdata : '0;
        end
    end

    // ------------------------------------------------------------
    // nominal ratings and thresholds
    // ------------------------------------------------------------
    // a lowered nominal does not re-clamp stored thresholds
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            nom_v_ff <= oevm_pkg::NOM_V_DEF;
            nom_i_ff <= oevm_pkg::NOM_I_DEF;
            nom_p_ff <= oevm_pkg::NOM_P_DEF;
        end else begin
            if (wr_nv) begin
                nom_v_ff <= wr_val;
            end
            if (wr_ni) begin
                nom_i_ff <= wr_val;
            end
            if (wr_np) begin
                nom_p_ff <= wr_val;
            end
        end
    end

    // thresholds settable from zero up to their nominal
    generate
        for (g = 0; g < NE; g++) begin : g_thr
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    thr_ff[g] <= oevm_pkg::THR_RST;
                end else if (wr_thr[g]) begin
                    thr_ff[g] <= clamp_thr(wr_val, thr_nom[g]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_out = rdata_ff;
    assign output_on_out = out_on_ff;
    assign irq_out = irq_ff;

endmodule : oevm_top

// ---- verification/oevm_plant_model.sv ----
// oevm_plant_model: power stage seen by the monitor's measurement pins
`timescale 1ns/10ps
module oevm_plant_model (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic output_on_in,
    input wire logic [15:0] set_volt_in,
    input wire logic [15:0] set_curr_in,
    input wire logic [15:0] set_pwr_in,
    output logic [15:0] meas_volt_out,
    output logic [15:0] meas_curr_out,
    output logic [15:0] meas_pwr_out
);
    // output capacitance keeps the voltage sinking slowly after switch-off,
    // which is what makes a late undervoltage tempting to flag
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meas_volt_out <= 16'h0000;
            meas_curr_out <= 16'h0000;
            meas_pwr_out <= 16'h0000;
        end else if (output_on_in) begin
            meas_volt_out <= set_volt_in;
            meas_curr_out <= set_curr_in;
            meas_pwr_out <= set_pwr_in;
        end else begin
            meas_volt_out <= (meas_volt_out > 16'h0004) ?
                meas_volt_out - 16'h0004 : 16'h0000;
            meas_curr_out <= 16'h0000;
            meas_pwr_out <= 16'h0000;
        end
    end
endmodule : oevm_plant_model

// ---- verification/oevm_top_asserts.sv ----
// oevm_top_asserts: port-level checker for the output event monitor
`timescale 1ns/10ps
module oevm_checker (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [oevm_pkg::MEAS_W-1:0] meas_volt_in,
    input wire logic [oevm_pkg::MEAS_W-1:0] meas_curr_in,
    input wire logic [oevm_pkg::MEAS_W-1:0] meas_pwr_in,
    input wire logic [oevm_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [oevm_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [oevm_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic output_on_out,
    input wire logic irq_out
);
    // --------------------------------------------------------------
    // decoded host writes
    // --------------------------------------------------------------
    wire logic ctrl_wr;
    wire logic on_wr;
    wire logic off_wr;
    wire logic mask_zero_wr;
    // off wins over on, so an on write must carry a clear off bit
    assign ctrl_wr = reg_wr_in && (reg_addr_in == oevm_pkg::REG_CTRL);
    assign on_wr = ctrl_wr && reg_wdata_in[0] && !reg_wdata_in[1];
    assign off_wr = ctrl_wr && reg_wdata_in[1];
    assign mask_zero_wr = reg_wr_in && (reg_addr_in == oevm_pkg::REG_MASK)
        && (reg_wdata_in[5:0] == 6'h00);

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    rdata_idle_a: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
        else $error("read data not zero outside a read");
    unmapped_rd_a: assert property (
        $past(reg_rd_in) && $past(reg_addr_in) > 4'hB
        |-> reg_rdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    stat_mirror_a: assert property (
        $past(reg_rd_in) && $past(reg_addr_in) == 4'h2
        |-> reg_rdata_out[6] == $past(output_on_out))
        else $error("output state misread");
    out_rise_a: assert property (
        $rose(output_on_out) |-> $past(on_wr) || $past(on_wr, 2))
        else $error("output switched on without a host command");
    off_write_a: assert property (off_wr |-> ##[1:2] !output_on_out)
        else $error("output still on after an off command");
    irq_fall_a: assert property (
        $fell(irq_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
        else $error("interrupt dropped without a host write");
    irq_rise_a: assert property (
        $rose(irq_out) |-> $past(output_on_out) || $past(output_on_out, 2)
        || $past(reg_wr_in) || $past(reg_wr_in, 2))
        else $error("event raised while output off");
    mask_clr_a: assert property (mask_zero_wr |=> ##1 !irq_out)
        else $error("interrupt high with all masks clear");
endmodule : oevm_checker

// ---- verification/tb_output_event_monitor.sv ----
// tb_output_event_monitor: self-checking bench of the output event monitor
`timescale 1ns/10ps
module tb_output_event_monitor;
    logic ref_clk_in;
    logic nrst_in;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic out_on;
    logic irq;
    logic [15:0] mv, mi, mp;
    logic [31:0] d;
    int num_errors = 0;
    int num_checks = 0;

    // clock at 20 MHz
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    // all conditions true at 100 against the thresholds set below
    oevm_plant_model u_plant (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .output_on_in(out_on), .set_volt_in(16'h0064),
        .set_curr_in(16'h0064), .set_pwr_in(16'h0064),
        .meas_volt_out(mv), .meas_curr_out(mi), .meas_pwr_out(mp));
    oevm_top u_dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .meas_volt_in(mv), .meas_curr_in(mi), .meas_pwr_in(mp),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .output_on_out(out_on), .irq_out(irq));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk_in);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr <= 1'b0;
    endtask : wr_reg

    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd_reg

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : wait_cyc

    task automatic final_report;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_state;
        rd_reg(oevm_pkg::REG_ACTION, d);
        check(d, 32'h0000_0000);
        rd_reg(4'hF, d);
        check(d, 32'h0000_0000);
        rd_reg(oevm_pkg::REG_NOMINAL_V, d);
        check(d, {16'h0000, oevm_pkg::NOM_V_DEF});
        wr_reg(oevm_pkg::REG_UV_THR, 32'h0000_00C8);
        wr_reg(oevm_pkg::REG_OV_THR, 32'h0000_0032);
        wr_reg(oevm_pkg::REG_UC_THR, 32'h0000_00C8);
        wr_reg(oevm_pkg::REG_OC_THR, 32'h0000_0032);
        wr_reg(oevm_pkg::REG_OP_THR, 32'h0000_0032);
        // every condition is true now, yet nothing is armed
        wr_reg(oevm_pkg::REG_CTRL, 32'h0000_0001);
        wait_cyc(10);
        rd_reg(oevm_pkg::REG_STATUS, d);
        check(d, 32'h0000_0040);
        wr_reg(oevm_pkg::REG_CTRL, 32'h0000_0002);
        $display("test reset_state done");
    endtask : t_reset_state

    // a threshold written above its nominal is held at the nominal
    task automatic t_clamp;
        wr_reg(oevm_pkg::REG_NOMINAL_P, 32'h0000_0080);
        wr_reg(oevm_pkg::REG_OP_THR, 32'h0000_0100);
        rd_reg(oevm_pkg::REG_OP_THR, d);
        check(d, 32'h0000_0080);
        wr_reg(oevm_pkg::REG_OP_THR, 32'h0000_0032);
        rd_reg(oevm_pkg::REG_OP_THR, d);
        check(d, 32'h0000_0032);
        wr_reg(oevm_pkg::REG_NOMINAL_P, 32'h0000_FFFF);
        $display("test clamp done");
    endtask : t_clamp

    // one event armed at a time while all five conditions hold
    task automatic t_each_event;
        oevm_pkg::oevm_action_t act;
        for (int ev = 0; ev < oevm_pkg::NUM_EV; ev++) begin
            act = ev[0] ? oevm_pkg::OEVM_ACT_WARNING
                : oevm_pkg::OEVM_ACT_SIGNAL;
            wr_reg(oevm_pkg::REG_ACTION, 32'(act) << (2 * ev));
            wr_reg(oevm_pkg::REG_CTRL, 32'h0000_0001);
            wait_cyc(10);
            rd_reg(oevm_pkg::REG_STATUS, d);
            check(d, (32'h1 << ev) | 32'h40);
            check({31'h0, out_on}, 32'h0000_0001);
            wr_reg(oevm_pkg::REG_CTRL, 32'h0000_0002);
            wait_cyc(10);
            rd_reg(oevm_pkg::REG_STATUS, d);
            check(d, 32'h1 << ev);
            wr_reg(oevm_pkg::REG_STATUS, 32'h0000_001F);
            rd_reg(oevm_pkg::REG_STATUS, d);
            check(d, 32'h0000_0000);
        end
        wr_reg(oevm_pkg::REG_ACTION, 32'h0000_0000);
        $display("test each_event done");
    endtask : t_each_event

    // arming an alarm with the output on trips it at once
    task automatic t_alarm;
        wr_reg(oevm_pkg::REG_MASK, 32'h0000_0008);
        wr_reg(oevm_pkg::REG_CTRL, 32'h0000_0001);
        wait_cyc(10);
        check({31'h0, out_on}, 32'h0000_0001);
        wr_reg(oevm_pkg::REG_ACTION, 32'h0000_00C0);
        wait_cyc(10);
        check({31'h0, out_on}, 32'h0000_0000);
        rd_reg(oevm_pkg::REG_STATUS, d);
        check(d, 32'h0000_0028);
        check({31'h0, irq}, 32'h0000_0001);
        wr_reg(oevm_pkg::REG_MASK, 32'h0000_0000);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0000_0000);
        wr_reg(oevm_pkg::REG_MASK, 32'h0000_0008);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0000_0001);
        wr_reg(oevm_pkg::REG_STATUS, 32'h0000_0028);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0000_0000);
        wr_reg(oevm_pkg::REG_ACTION, 32'h0000_0000);
        $display("test alarm done");
    endtask : t_alarm

    // sinking voltage and zero current after switch-off raise nothing
    task automatic t_decay;
        wr_reg(oevm_pkg::REG_UV_THR, 32'h0000_0032);
        wr_reg(oevm_pkg::REG_UC_THR, 32'h0000_0032);
        wr_reg(oevm_pkg::REG_CTRL, 32'h0000_0001);
        wait_cyc(10);
        wr_reg(oevm_pkg::REG_ACTION, 32'h0000_0011);
        wait_cyc(10);
        rd_reg(oevm_pkg::REG_STATUS, d);
        check(d, 32'h0000_0040);
        wr_reg(oevm_pkg::REG_CTRL, 32'h0000_0002);
        wait_cyc(40);
        rd_reg(oevm_pkg::REG_STATUS, d);
        check(d, 32'h0000_0000);
        $display("test decay done");
    endtask : t_decay

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        nrst_in = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        wait_cyc(2);
        nrst_in <= 1'b1;
        t_reset_state();
        t_clamp();
        t_each_event();
        t_alarm();
        t_decay();
        final_report();
    end

    // tests take well under a thousand cycles
    initial begin
        #(5000 * 50);
        num_errors++;
        final_report();
    end
endmodule : tb_output_event_monitor

bind oevm_top oevm_checker u_chk (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .meas_volt_in(meas_volt_in), .meas_curr_in(meas_curr_in),
    .meas_pwr_in(meas_pwr_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .output_on_out(output_on_out),
    .irq_out(irq_out));
